//--- shared/ascfm_pkg.sv
// Purpose: Shared constants for the serial flag and mode block
// Assumes: 8-bit register port, 3-bit register address
// Notes: Offsets and bit positions are byte-register based

package ascfm_pkg;

	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam int ADDR_W = 3;
	localparam logic [2:0] OFS_CTRL1 = 3'h0;
	localparam logic [2:0] OFS_CTRL2 = 3'h1;
	localparam logic [2:0] OFS_STAT1 = 3'h2;
	localparam logic [2:0] OFS_STAT2 = 3'h3;
	localparam logic [2:0] OFS_CTRL3 = 3'h4;
	localparam logic [2:0] OFS_DATA = 3'h5;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int C1_LOOP = 7;
	localparam int C1_RECEIVER_SOURCE_SEL = 5;
	localparam int C1_NINE = 4;
	localparam int C2_TIE = 7;
	localparam int C2_TX_COMPLETE_IRQ_EN = 6;
	localparam int C2_RIE = 5;
	localparam int C2_ILIE = 4;
	localparam int C2_TE = 3;
	localparam int C2_RE = 2;
	localparam int S1_TX_BUFFER_EMPTY = 7;
	localparam int S1_TC = 6;
	localparam int S1_RX_BUFFER_FULL = 5;
	localparam int S1_IDLE = 4;
	localparam int S1_OVR = 3;
	localparam int S1_NF = 2;
	localparam int S1_FE = 1;
	localparam int S1_PF = 0;
	localparam int S2_BRKF = 7;
	localparam int S2_EDGF = 6;
	localparam int S2_BRKIE = 1;
	localparam int S2_EDGIE = 0;
	localparam int C3_R8 = 7;
	localparam int C3_T8 = 6;
	localparam int C3_DIR = 5;
	localparam int C3_ORIE = 3;
	localparam int C3_NEIE = 2;
	localparam int C3_FEIE = 1;
	localparam int C3_PEIE = 0;

	// ----------------------------------------
	// Reset values and the third control write mask
	// ----------------------------------------
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic TX_BUFFER_EMPTY_RST = 1'b1;
	localparam logic TC_RST = 1'b1;
	localparam logic IDLE_ARM_RST = 1'b1;
	localparam logic LINE_RST = 1'b1;
	localparam logic [7:0] WRITABLE_C3 = 8'h6f;

	// ----------------------------------------
	// Stop modes
	// ----------------------------------------
	localparam logic [1:0] STOP_RUN = 2'h0;
	localparam logic [1:0] STOP_LIGHT = 2'h1;
	localparam logic [1:0] STOP_MID = 2'h2;
	localparam logic [1:0] STOP_DEEP = 2'h3;

endpackage

//--- rtl/ascfm_edge_det.sv
// Purpose: Falling-edge detector on the selected receive line
// Assumes: Line already synchronous to core_clk
// Notes: Pulse output is registered, one cycle after the edge

`timescale 1ns/10ps

module ascfm_edge_det (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic sampleEn,
	input wire logic lineIn,
	output logic edgePulse
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic prevLine;
		logic pulse;
	} ascfm_edge_t;

	ascfm_edge_t st_r;
	ascfm_edge_t st_nxt;

	always_comb begin
		st_nxt = st_r;
		st_nxt.pulse = 1'b0;
		if (sampleEn) begin
			// Idle level is high, so the active edge is high to low
			st_nxt.pulse = st_r.prevLine & ~lineIn;
			st_nxt.prevLine = lineIn;
		end else begin
			// Restart at idle so waking gives no false edge
			st_nxt.prevLine = ascfm_pkg::LINE_RST;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r.prevLine <= ascfm_pkg::LINE_RST;
			st_r.pulse <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign edgePulse = st_r.pulse;

endmodule

//--- rtl/ascfm_flags_modes.sv
// Purpose: Status flags, grouped interrupt requests, ninth-bit, stop and loop modes of a serial port
// Assumes: Shifters, baud and sampling live outside and talk through the engine ports
// Notes: All pins and engine inputs are synchronous to core_clk
//
// Contract
// - Three interrupt outputs over ten sources, each source with its own enable.
// - Flags set and read regardless of enables; enables only gate requests.
// - Transmit-empty flags free buffer space; requests interrupt while set and enabled.
// - Transmit-complete sets when transmitter idle; requests interrupt while set and enabled.
// - Receive-full clears after status read while set, then data read.
// - Idle clears after status read while set, then data read.
// - Idle cannot set again until a new character sets receive-full.
// - Noise, framing, parity set with receive-full; never on overrun.
// - New character while receive-full set raises overrun and is dropped; with framing error set the code drops it without raising overrun.
// - Active receive edge sets edge flag while receiver enabled; write one clears.
// - Character-length bit picks nine bits; ninth bits live in third control.
// - Ninth transmit bit copied with byte into shifter; kept until rewritten.
// - Clocks halt in stop; two deepest lose registers; lightest keeps them.
// - Edge detector stays alive in lightest stop and wakes when enabled.
// - With loop enable, source bit picks internal loop or single wire.
// - Loop mode feeds transmitter to receiver and releases receive pin.
// - Single wire ties receiver to transmitter and transmit pin; releases receive pin.
// - Single wire direction zero makes pin input; one drives it from transmitter.
// - Single wire receiver also hears every transmitted character while direction is one; with direction zero it hears only the pin.
// - While framing error set, no completed character enters the receive buffer.
//
// Design decisions made here: the plain strobed port and the address map.

`timescale 1ns/10ps

module ascfm_flags_modes (
	input wire logic core_clk,
	input wire logic sys_rst,
	// Register port
	input wire logic [2:0] regAddr,
	input wire logic [7:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdata,
	// Power mode
	input wire logic [1:0] stopMode,
	output logic moduleClkEn,
	output logic wakeRequest,
	// Transmit engine
	input wire logic txLoad,
	input wire logic txIdle,
	input wire logic txSerial,
	output logic [7:0] txShiftData,
	output logic txShiftNinth,
	output logic txPending,
	output logic txEnable,
	// Receive engine
	input wire logic rxDone,
	input wire logic [8:0] rxWord,
	input wire logic rxNoise,
	input wire logic rxFrameErr,
	input wire logic rxParityErr,
	input wire logic idleDetect,
	input wire logic breakDetect,
	output logic rxLine,
	output logic rxEnable,
	output logic rxTransferBlock,
	output logic nineBitMode,
	// Pins
	input wire logic rxdPinIn,
	input wire logic txdPinIn,
	output logic txdPinOut,
	output logic txdPinOe,
	output logic rxdPinOwned,
	// Interrupt requests
	output logic irqTx,
	output logic irqRx,
	output logic irqErr
);

	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] ctrl1;
		logic [7:0] ctrl2;
		logic [7:0] ctrl3;
		logic [1:0] s2En;
		logic [7:0] txBuf;
		logic [7:0] txShift;
		logic txNinth;
		logic [8:0] rxBuf;
		logic tx_buffer_empty;
		logic tc;
		logic rx_buffer_full;
		logic idle;
		logic ovr;
		logic nf;
		logic fe;
		logic pf;
		logic edgf;
		logic brkf;
		logic [5:0] armed;
		logic idleArmed;
		logic [7:0] rdata;
	} ascfm_state_t;

	localparam ascfm_state_t ST_RST = '{
		ctrl1: ascfm_pkg::CTRL_RST,
		ctrl2: ascfm_pkg::CTRL_RST,
		ctrl3: ascfm_pkg::CTRL_RST,
		s2En: 2'h0,
		txBuf: 8'h00,
		txShift: 8'h00,
		txNinth: 1'b0,
		rxBuf: 9'h000,
		tx_buffer_empty: ascfm_pkg::TX_BUFFER_EMPTY_RST,
		tc: ascfm_pkg::TC_RST,
		rx_buffer_full: 1'b0,
		idle: 1'b0,
		ovr: 1'b0,
		nf: 1'b0,
		fe: 1'b0,
		pf: 1'b0,
		edgf: 1'b0,
		brkf: 1'b0,
		armed: 6'h00,
		idleArmed: ascfm_pkg::IDLE_ARM_RST,
		rdata: 8'h00
	};

	ascfm_state_t st_r;
	ascfm_state_t st_nxt;

	logic running;
	logic lightStop;
	logic deepStop;
	logic loopOn;
	logic singleWire;
	logic edgePulse;
	logic [7:0] stat1View;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic hit(input logic strobe, input logic [2:0] addr, input logic [2:0] ofs);
		hit = strobe & (addr == ofs);
	endfunction

	// Module clock runs only outside stop; the two deepest modes also wipe state
	assign running = (stopMode == ascfm_pkg::STOP_RUN);
	assign lightStop = (stopMode == ascfm_pkg::STOP_LIGHT);
	assign deepStop = (stopMode == ascfm_pkg::STOP_MID) | (stopMode == ascfm_pkg::STOP_DEEP);

	assign loopOn = st_r.ctrl1[ascfm_pkg::C1_LOOP] & ~st_r.ctrl1[ascfm_pkg::C1_RECEIVER_SOURCE_SEL];
	assign singleWire = st_r.ctrl1[ascfm_pkg::C1_LOOP] & st_r.ctrl1[ascfm_pkg::C1_RECEIVER_SOURCE_SEL];

	assign stat1View = {st_r.tx_buffer_empty, st_r.tc, st_r.rx_buffer_full, st_r.idle, st_r.ovr, st_r.nf, st_r.fe, st_r.pf};

	// ----------------------------------------
	// Line routing
	// ----------------------------------------
	always_comb begin
		if (loopOn) begin
			rxLine = txSerial;
		end else if (singleWire) begin
			// Driving the pin ourselves means the pin equals the transmitter
			rxLine = st_r.ctrl3[ascfm_pkg::C3_DIR] ? txSerial : txdPinIn;
		end else begin
			rxLine = rxdPinIn;
		end
	end

	assign txdPinOut = txSerial;
	assign txdPinOe = singleWire ? st_r.ctrl3[ascfm_pkg::C3_DIR] : st_r.ctrl2[ascfm_pkg::C2_TE];
	assign rxdPinOwned = ~st_r.ctrl1[ascfm_pkg::C1_LOOP];

	// ----------------------------------------
	// Edge detector
	// ----------------------------------------
	// Kept alive in the lightest stop so a line edge can wake the core
	ascfm_edge_det u_edge (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.sampleEn((running | lightStop) & st_r.ctrl2[ascfm_pkg::C2_RE]),
		.lineIn(rxLine),
		.edgePulse(edgePulse)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		if (deepStop) begin
			st_nxt = ST_RST;
		end else if (lightStop) begin
			// Everything frozen except the edge flag
			// Read data is a bus answer, not a register, so it still stands one cycle only
			st_nxt.rdata = 8'h00;
			if (edgePulse) begin
				st_nxt.edgf = 1'b1;
			end
		end else begin
			st_nxt.rdata = 8'h00;

			// Register writes
			if (hit(regWr, regAddr, ascfm_pkg::OFS_CTRL1)) begin
				st_nxt.ctrl1 = regWdata;
			end else if (hit(regWr, regAddr, ascfm_pkg::OFS_CTRL2)) begin
				st_nxt.ctrl2 = regWdata;
			end else if (hit(regWr, regAddr, ascfm_pkg::OFS_CTRL3)) begin
				// Receive ninth bit is read-only
				st_nxt.ctrl3 = regWdata & ascfm_pkg::WRITABLE_C3;
			end else if (hit(regWr, regAddr, ascfm_pkg::OFS_STAT2)) begin
				st_nxt.s2En = regWdata[1:0];
				if (regWdata[ascfm_pkg::S2_EDGF]) begin
					st_nxt.edgf = 1'b0;
				end
				if (regWdata[ascfm_pkg::S2_BRKF]) begin
					st_nxt.brkf = 1'b0;
				end
			end else if (hit(regWr, regAddr, ascfm_pkg::OFS_DATA)) begin
				st_nxt.txBuf = regWdata;
				st_nxt.tx_buffer_empty = 1'b0;
				st_nxt.tc = 1'b0;
			end

			// Transmit side
			if (txLoad & ~st_r.tx_buffer_empty) begin
				st_nxt.txShift = st_r.txBuf;
				st_nxt.txNinth = st_r.ctrl3[ascfm_pkg::C3_T8];
				st_nxt.tx_buffer_empty = 1'b1;
			end
			// A data write in this cycle means the line is not finished after all
			if (txIdle & st_r.tx_buffer_empty & ~hit(regWr, regAddr, ascfm_pkg::OFS_DATA)) begin
				st_nxt.tc = 1'b1;
			end

			// Status read arms the clear of whatever is set now
			if (hit(regRd, regAddr, ascfm_pkg::OFS_STAT1)) begin
				st_nxt.armed = {st_r.rx_buffer_full, st_r.idle, st_r.ovr, st_r.nf, st_r.fe, st_r.pf};
			end

			// Data read finishes the sequence
			if (hit(regRd, regAddr, ascfm_pkg::OFS_DATA)) begin
				st_nxt.armed = 6'h00;
				if (st_r.armed[5]) begin
					st_nxt.rx_buffer_full = 1'b0;
				end
				if (st_r.armed[4]) begin
					st_nxt.idle = 1'b0;
				end
				if (st_r.armed[3]) begin
					st_nxt.ovr = 1'b0;
				end
				if (st_r.armed[2]) begin
					st_nxt.nf = 1'b0;
				end
				if (st_r.armed[1]) begin
					st_nxt.fe = 1'b0;
				end
				if (st_r.armed[0]) begin
					st_nxt.pf = 1'b0;
				end
			end

			// Receive side; sets come after clears so a set wins
			if (rxDone & st_r.ctrl2[ascfm_pkg::C2_RE]) begin
				if (st_r.fe) begin
					// Shifter keeps running but its character is dropped
					st_nxt.rxBuf = st_r.rxBuf;
				end else if (st_r.rx_buffer_full) begin
					st_nxt.ovr = 1'b1;
				end else begin
					st_nxt.rxBuf = st_r.ctrl1[ascfm_pkg::C1_NINE] ? rxWord : {1'b0, rxWord[7:0]};
					st_nxt.rx_buffer_full = 1'b1;
					st_nxt.nf = rxNoise;
					st_nxt.fe = rxFrameErr;
					st_nxt.pf = rxParityErr;
					st_nxt.idleArmed = 1'b1;
				end
			end
			if (idleDetect & st_r.idleArmed & st_r.ctrl2[ascfm_pkg::C2_RE]) begin
				st_nxt.idle = 1'b1;
				st_nxt.idleArmed = 1'b0;
			end
			if (edgePulse) begin
				st_nxt.edgf = 1'b1;
			end
			if (breakDetect) begin
				st_nxt.brkf = 1'b1;
			end

			// Read data, one cycle after the strobe
			if (hit(regRd, regAddr, ascfm_pkg::OFS_CTRL1)) begin
				st_nxt.rdata = st_r.ctrl1;
			end else if (hit(regRd, regAddr, ascfm_pkg::OFS_CTRL2)) begin
				st_nxt.rdata = st_r.ctrl2;
			end else if (hit(regRd, regAddr, ascfm_pkg::OFS_STAT1)) begin
				st_nxt.rdata = stat1View;
			end else if (hit(regRd, regAddr, ascfm_pkg::OFS_STAT2)) begin
				st_nxt.rdata = {st_r.brkf, st_r.edgf, 4'h0, st_r.s2En};
			end else if (hit(regRd, regAddr, ascfm_pkg::OFS_CTRL3)) begin
				st_nxt.rdata = {st_r.rxBuf[8], st_r.ctrl3[6:0]};
			end else if (hit(regRd, regAddr, ascfm_pkg::OFS_DATA)) begin
				st_nxt.rdata = st_r.rxBuf[7:0];
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign regRdata = st_r.rdata;
	assign moduleClkEn = running;
	// Level stays up only while in the lightest stop; it drops when stopMode leaves it, even with the edge flag still set
	assign wakeRequest = lightStop & st_r.edgf & st_r.s2En[ascfm_pkg::S2_EDGIE];
	assign txShiftData = st_r.txShift;
	assign txShiftNinth = st_r.txNinth;
	assign txPending = ~st_r.tx_buffer_empty;
	assign txEnable = st_r.ctrl2[ascfm_pkg::C2_TE];
	assign rxEnable = st_r.ctrl2[ascfm_pkg::C2_RE];
	assign rxTransferBlock = st_r.fe;
	assign nineBitMode = st_r.ctrl1[ascfm_pkg::C1_NINE];

	// Enables gate only the requests, never the flags
	assign irqTx = (st_r.tx_buffer_empty & st_r.ctrl2[ascfm_pkg::C2_TIE])
		| (st_r.tc & st_r.ctrl2[ascfm_pkg::C2_TX_COMPLETE_IRQ_EN]);
	assign irqRx = (st_r.rx_buffer_full & st_r.ctrl2[ascfm_pkg::C2_RIE])
		| (st_r.idle & st_r.ctrl2[ascfm_pkg::C2_ILIE])
		| (st_r.edgf & st_r.s2En[ascfm_pkg::S2_EDGIE])
		| (st_r.brkf & st_r.s2En[ascfm_pkg::S2_BRKIE]);
	assign irqErr = (st_r.ovr & st_r.ctrl3[ascfm_pkg::C3_ORIE])
		| (st_r.nf & st_r.ctrl3[ascfm_pkg::C3_NEIE])
		| (st_r.fe & st_r.ctrl3[ascfm_pkg::C3_FEIE])
		| (st_r.pf & st_r.ctrl3[ascfm_pkg::C3_PEIE]);

endmodule

//--- test/ascfm_remote_node.sv
// Purpose: Remote serial node on the receive and transmit pins
// Assumes: Idle line is high, pins pulled up when nobody drives
// Notes: Only pulls the line low and releases it; character framing stays with the engine stand-in

`timescale 1ns/10ps

module ascfm_remote_node (
	input wire logic pullLow,
	input wire logic dutOe,
	input wire logic dutOut,
	output logic rxdPin,
	output logic txdWire
);
	// Released pins go to the pull-up level, never hold the last value
	assign rxdPin = !pullLow;
	// Shared wire follows the block only while its enable is high
	assign txdWire = dutOe ? dutOut : !pullLow;
endmodule

//--- test/ascfm_assertions.sv
// Purpose: Port-level checks of the serial flag and mode block
// Assumes: One clock, synchronous active high reset
// Notes: Flags are hidden, so checks lean on their mirror outputs

`timescale 1ns/10ps

module ascfm_assertions (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [1:0] stopMode,
	input wire logic moduleClkEn,
	input wire logic wakeRequest,
	input wire logic txLoad,
	input wire logic txSerial,
	input wire logic [7:0] txShiftData,
	input wire logic txPending,
	input wire logic txEnable,
	input wire logic rxLine,
	input wire logic rxEnable,
	input wire logic rxTransferBlock,
	input wire logic rxdPinIn,
	input wire logic txdPinOut,
	input wire logic txdPinOe,
	input wire logic rxdPinOwned
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	// A load counts only when software is not writing in that same cycle
	sequence s_load;
		txLoad && txPending && stopMode == 2'h0 && !regWr;
	endsequence
	a_clk_gate: assert property (moduleClkEn == (stopMode == 2'h0))
		else $error("module clock not gated by stop");
	a_deep_loss: assert property (stopMode[1] |=> !txPending && !txEnable && !rxEnable && !rxTransferBlock)
		else $error("deep stop kept state");
	a_light_keep: assert property (stopMode == 2'h1 |=> $stable(txEnable) && $stable(rxEnable) && $stable(txShiftData))
		else $error("light stop lost state");
	a_wake_light: assert property (wakeRequest |-> stopMode == 2'h1)
		else $error("wake outside light stop");
	a_load_empty: assert property (s_load |=> !txPending)
		else $error("buffer not empty after load");
	a_shift_hold: assert property (!txLoad && stopMode == 2'h0 |=> $stable(txShiftData))
		else $error("shift data moved without load");
	a_frame_hold: assert property (rxTransferBlock && !regRd && !stopMode[1] |=> rxTransferBlock)
		else $error("framing block dropped early");
	a_pin_normal: assert property (rxdPinOwned |-> rxLine == rxdPinIn && txdPinOe == txEnable)
		else $error("normal mode path wrong");
	a_loop_feed: assert property (!rxdPinOwned && txdPinOe |-> rxLine == txSerial)
		else $error("loop path wrong");
	a_pin_follow: assert property (txdPinOut == txSerial)
		else $error("pin not from transmitter");
endmodule

bind ascfm_flags_modes ascfm_assertions chk_u (.core_clk, .sys_rst, .regWr, .regRd, .stopMode, .moduleClkEn,
	.wakeRequest, .txLoad, .txSerial, .txShiftData, .txPending, .txEnable, .rxLine, .rxEnable, .rxTransferBlock,
	.rxdPinIn, .txdPinOut, .txdPinOe, .rxdPinOwned);

//--- test/ascfm_flags_modes_tb.sv
// Purpose: Self-checking bench for the serial flag and mode block
// Assumes: Engine ports are driven here in place of the shifters
// Notes: Fixed waits follow the one-cycle latencies of the block

`timescale 1ns/10ps

module ascfm_flags_modes_tb;
	logic core_clk = 1'h0, sys_rst = 1'h1, regWr = 1'h0, regRd = 1'h0, txLoad = 1'h0, txIdle = 1'h0;
	logic txSerial = 1'h1, rxDone = 1'h0, rxNoise = 1'h0, rxFrameErr = 1'h0, rxParityErr = 1'h0;
	logic idleDetect = 1'h0, breakDetect = 1'h0, pullLow = 1'h0;
	logic [2:0] regAddr = 3'h0;
	logic [7:0] regWdata = 8'h00, regRdata, txShiftData, d;
	logic [1:0] stopMode = 2'h0;
	logic [8:0] rxWord = 9'h000;
	logic moduleClkEn, wakeRequest, txShiftNinth, txPending, txEnable, rxLine, rxEnable, rxTransferBlock;
	logic nineBitMode, rxdPinIn, txdPinIn, txdPinOut, txdPinOe, rxdPinOwned, irqTx, irqRx, irqErr;
	int err_total = 0;
	int check_count = 0;
	typedef struct {logic [2:0] a; logic [7:0] w; logic [7:0] r;} ascfm_row_t;
	ascfm_row_t rows [6] = '{'{ascfm_pkg::OFS_CTRL2, 8'h0c, 8'h0c}, '{ascfm_pkg::OFS_CTRL3, 8'hff, 8'h6f},
		'{ascfm_pkg::OFS_STAT2, 8'hff, 8'h03}, '{ascfm_pkg::OFS_STAT1, 8'h00, 8'hc0},
		'{3'h6, 8'h55, 8'h00}, '{ascfm_pkg::OFS_CTRL1, 8'h30, 8'h30}};

	ascfm_flags_modes dut_u (.core_clk, .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .stopMode,
		.moduleClkEn, .wakeRequest, .txLoad, .txIdle, .txSerial, .txShiftData, .txShiftNinth, .txPending, .txEnable,
		.rxDone, .rxWord, .rxNoise, .rxFrameErr, .rxParityErr, .idleDetect, .breakDetect, .rxLine, .rxEnable,
		.rxTransferBlock, .nineBitMode, .rxdPinIn, .txdPinIn, .txdPinOut, .txdPinOe, .rxdPinOwned, .irqTx, .irqRx,
		.irqErr);
	ascfm_remote_node node_u (.pullLow, .dutOe(txdPinOe), .dutOut(txdPinOut), .rxdPin(rxdPinIn), .txdWire(txdPinIn));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wr(logic [2:0] a, logic [7:0] w);
		@(posedge core_clk);
		regAddr <= a;
		regWdata <= w;
		regWr <= 1'h1;
		@(posedge core_clk);
		regWr <= 1'h0;
		#1;
	endtask
	task automatic rd(logic [2:0] a);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'h1;
		@(posedge core_clk);
		regRd <= 1'h0;
		#1 d = regRdata;
	endtask
	task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
		check_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk1(string n, logic e, logic g);
		chk8(n, {7'h00, e}, {7'h00, g});
	endtask
	task automatic load();
		@(posedge core_clk);
		txLoad <= 1'h1;
		@(posedge core_clk);
		txLoad <= 1'h0;
		#1;
	endtask
	task automatic rxChar(logic [8:0] w, logic [2:0] e);
		@(posedge core_clk);
		rxWord <= w;
		{rxNoise, rxFrameErr, rxParityErr} <= e;
		rxDone <= 1'h1;
		@(posedge core_clk);
		rxDone <= 1'h0;
		#1;
	endtask
	// Idle pulse and line edge share one strobe shape
	task automatic strobe(logic sel);
		@(posedge core_clk);
		if (sel) idleDetect <= 1'h1; else pullLow <= 1'h1;
		@(posedge core_clk);
		idleDetect <= 1'h0;
		pullLow <= 1'h0;
		repeat (3) @(posedge core_clk);
		#1;
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	initial begin
		forever #20 core_clk = ~core_clk;
	end
	initial begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		complete_run();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		sys_rst <= 1'h0;
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			rd(rows[i].a);
			chk8("row readback", rows[i].r, d);
		end
		@(posedge core_clk);
		sys_rst <= 1'h1;
		@(posedge core_clk);
		sys_rst <= 1'h0;
		rd(ascfm_pkg::OFS_CTRL2);
		chk8("ctrl after reset", 8'h00, d);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("status after reset", 8'hc0, d);
		// Transmit path, ninth bit written before data as software must
		wr(ascfm_pkg::OFS_CTRL2, 8'h88);
		chk1("tx irq empty", 1'h1, irqTx);
		wr(ascfm_pkg::OFS_CTRL1, 8'h10);
		chk1("nine mode", 1'h1, nineBitMode);
		wr(ascfm_pkg::OFS_CTRL3, 8'h40);
		wr(ascfm_pkg::OFS_DATA, 8'ha5);
		chk1("tx irq full", 1'h0, irqTx);
		load();
		chk8("shift byte", 8'ha5, txShiftData);
		chk1("shift ninth", 1'h1, txShiftNinth);
		wr(ascfm_pkg::OFS_DATA, 8'h3c);
		load();
		chk1("ninth kept", 1'h1, txShiftNinth);
		wr(ascfm_pkg::OFS_CTRL3, 8'h00);
		wr(ascfm_pkg::OFS_DATA, 8'h5a);
		load();
		chk1("ninth new", 1'h0, txShiftNinth);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("tc busy", 8'h80, d & 8'hc0);
		txIdle <= 1'h1;
		wr(ascfm_pkg::OFS_CTRL2, 8'h48);
		chk1("tc irq", 1'h1, irqTx);
		wr(ascfm_pkg::OFS_DATA, 8'h77);
		chk1("tc on write", 1'h0, irqTx);
		// Receive path with errors, overrun and the clearing sequence
		wr(ascfm_pkg::OFS_CTRL2, 8'h24);
		wr(ascfm_pkg::OFS_CTRL3, 8'h04);
		rxChar(9'h15a, 3'h5);
		chk1("rx irq", 1'h1, irqRx);
		chk1("err irq", 1'h1, irqErr);
		rxChar(9'h0a0, 3'h2);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("overrun status", 8'h2d, d & 8'h3f);
		rd(ascfm_pkg::OFS_DATA);
		chk8("rx byte", 8'h5a, d);
		rd(ascfm_pkg::OFS_CTRL3);
		chk8("rx ninth", 8'h84, d);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("rx cleared", 8'h00, d & 8'h3f);
		strobe(1'h1);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("idle set", 8'h10, d & 8'h3f);
		chk1("idle masked", 1'h0, irqRx);
		rd(ascfm_pkg::OFS_DATA);
		strobe(1'h1);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("idle rearm", 8'h00, d & 8'h3f);
		rxChar(9'h0ff, 3'h2);
		chk1("frame block", 1'h1, rxTransferBlock);
		rxChar(9'h011, 3'h0);
		rd(ascfm_pkg::OFS_STAT1);
		chk8("frame drop", 8'h22, d & 8'h3f);
		rd(ascfm_pkg::OFS_DATA);
		chk8("frame byte", 8'hff, d);
		chk1("frame clear", 1'h0, rxTransferBlock);
		// Line edge flag, receiver gating, stop modes
		strobe(1'h0);
		rd(ascfm_pkg::OFS_STAT2);
		chk8("edge flag", 8'h40, d & 8'hc0);
		wr(ascfm_pkg::OFS_STAT2, 8'h41);
		wr(ascfm_pkg::OFS_CTRL2, 8'h00);
		strobe(1'h0);
		rd(ascfm_pkg::OFS_STAT2);
		chk8("edge gated", 8'h00, d & 8'hc0);
		breakDetect <= 1'h1;
		@(posedge core_clk);
		breakDetect <= 1'h0;
		rd(ascfm_pkg::OFS_STAT2);
		chk8("break flag", 8'h81, d);
		chk1("break masked", 1'h0, irqRx);
		wr(ascfm_pkg::OFS_STAT2, 8'h02);
		chk1("break irq", 1'h1, irqRx);
		wr(ascfm_pkg::OFS_STAT2, 8'h81);
		chk1("break clear", 1'h0, irqRx);
		wr(ascfm_pkg::OFS_CTRL2, 8'h24);
		stopMode <= 2'h1;
		strobe(1'h0);
		chk1("wake", 1'h1, wakeRequest);
		chk1("clock off", 1'h0, moduleClkEn);
		stopMode <= 2'h0;
		rd(ascfm_pkg::OFS_CTRL2);
		chk8("light kept", 8'h24, d);
		stopMode <= 2'h2;
		repeat (2) @(posedge core_clk);
		stopMode <= 2'h0;
		rd(ascfm_pkg::OFS_CTRL2);
		chk8("deep lost", 8'h00, d);
		// Loop and single-wire modes
		wr(ascfm_pkg::OFS_CTRL2, 8'h08);
		txSerial <= 1'h0;
		wr(ascfm_pkg::OFS_CTRL1, 8'h80);
		chk1("pin released", 1'h0, rxdPinOwned);
		chk1("loop line", 1'h0, rxLine);
		wr(ascfm_pkg::OFS_CTRL1, 8'ha0);
		chk1("wire input", 1'h0, txdPinOe);
		chk1("wire hears pin", 1'h1, rxLine);
		wr(ascfm_pkg::OFS_CTRL3, 8'h20);
		chk1("wire drive", 1'h1, txdPinOe);
		chk1("wire echo", 1'h0, rxLine);
		complete_run();
	end
endmodule
